// file: core/timer_capture_compare_unit.v
// Capture/compare unit of a 16-bit free-running timer with clock selection.
// Assumes one clock; pins and strobes synchronous to it; one-cycle strobes.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_regs.vh"

module timer_capture_compare_unit (
  input  wire                   i_ref_clk,
  input  wire                   i_srst,
  input  wire [`TCC_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  input  wire                   i_cpu_irq_mask,
  input  wire                   i_ext_count_pin,
  input  wire [1:0]             i_capture_input_pin,
  output reg  [7:0]             o_rdata,
  output reg  [1:0]             o_compare_output_pin,
  output reg  [1:0]             o_compare_pin_oe,
  output reg                    o_timer_irq
);

  reg  [7:0]  timer_ctrl_one;
  reg  [7:0]  timer_ctrl_two;
  reg  [15:0] counter;
  reg  [15:0] capture_value [0:1];
  reg  [15:0] compare_value [0:1];
  reg  [1:0]  capture_flag;
  reg  [1:0]  compare_flag;
  reg  [1:0]  cap_blocked;
  reg  [1:0]  cmp_blocked;
  reg  [1:0]  cap_armed;
  reg  [1:0]  cmp_armed;
  reg  [1:0]  cap_pin_d;
  reg         ext_pin_d;
  reg  [2:0]  prescale;
  reg         tick_d;
  reg  [7:0]  cmp_lo_buf [0:1];

  wire [1:0]  clock_sel_field = {timer_ctrl_two[`TCC_C2_CLK_HI], timer_ctrl_two[`TCC_C2_CLK_LO]};
  wire        special_mode    = timer_ctrl_two[`TCC_C2_ONE_PULSE] | timer_ctrl_two[`TCC_C2_PWM];
  wire [1:0]  pin_enable      = {timer_ctrl_two[`TCC_C2_PIN2_EN], timer_ctrl_two[`TCC_C2_PIN1_EN]};
  wire [1:0]  out_level       = {timer_ctrl_one[`TCC_C1_LVL2], timer_ctrl_one[`TCC_C1_LVL1]};
  wire [1:0]  force_bits      = {timer_ctrl_one[`TCC_C1_FORCE2], timer_ctrl_one[`TCC_C1_FORCE1]};
  wire [1:0]  edge_sel        = {timer_ctrl_two[`TCC_C2_EDGE2], timer_ctrl_one[`TCC_C1_EDGE1]};

  // Selected edge detect, shared by the external clock and capture inputs.
  function edge_hit;
    input prev;
    input cur;
    input rising;
    begin
      edge_hit = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  function is_access;
    input [`TCC_ADDR_W-1:0] a;
    input [`TCC_ADDR_W-1:0] target;
    input                   rd;
    input                   wr;
    begin
      is_access = (rd | wr) & (a == target);
    end
  endfunction

  // Prescaler wraps at 8, so its low 1, 2 or 3 bits all high mark a divide-by-2, 4 or 8 tick.
  wire ext_edge = edge_hit(ext_pin_d, i_ext_count_pin, timer_ctrl_two[`TCC_C2_EXT_EDGE]);
  reg  tick;
  always @* begin
    case (clock_sel_field)
      `TCC_CLK_DIV2: tick = (prescale[0] == 1'b1);
      `TCC_CLK_DIV4: tick = (prescale[1:0] == 2'h3);
      `TCC_CLK_DIV8: tick = (prescale == 3'h7);
      default:       tick = ext_edge;
    endcase
  end

  // Compare target: plain value at divide-by-2, value plus one at divide-by-4, divide-by-8 and external clock.
  wire plus_one = (clock_sel_field != `TCC_CLK_DIV2);

  wire st_rd = i_rd & (i_addr == `TCC_A_STATUS);

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      prescale  <= 3'h0;
      ext_pin_d <= 1'b0;
      counter   <= `TCC_CNT_RESET;
      tick_d    <= 1'b0;
    end else begin
      prescale  <= prescale + 3'h1;
      ext_pin_d <= i_ext_count_pin;
      // The counter moves only on the tick cycle; external edges need two
      // clocks of spacing from the source or ticks are merged.
      tick_d    <= tick;
      if (tick) begin
        counter <= counter + 16'h0001;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [`TCC_ADDR_W-1:0] a_cap_hi = (ch == 0) ? `TCC_A_CAP1_HI : `TCC_A_CAP2_HI;
      wire [`TCC_ADDR_W-1:0] a_cap_lo = (ch == 0) ? `TCC_A_CAP1_LO : `TCC_A_CAP2_LO;
      wire [`TCC_ADDR_W-1:0] a_cmp_hi = (ch == 0) ? `TCC_A_CMP1_HI : `TCC_A_CMP2_HI;
      wire [`TCC_ADDR_W-1:0] a_cmp_lo = (ch == 0) ? `TCC_A_CMP1_LO : `TCC_A_CMP2_LO;
      wire cap_en   = (ch == 1) | ~special_mode;
      wire cap_evt  = cap_en & ~cap_blocked[ch] &
                      edge_hit(cap_pin_d[ch], i_capture_input_pin[ch], edge_sel[ch]);
      wire [15:0] target = compare_value[ch] + {15'h0, plus_one};
      wire cmp_evt  = tick_d & ~cmp_blocked[ch] & (counter == target);
      wire cmp_flag_ok = ~special_mode;
      wire cap_lo_acc = is_access(i_addr, a_cap_lo, i_rd, i_wr);
      wire cmp_lo_acc = is_access(i_addr, a_cmp_lo, i_rd, i_wr);

      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          cap_pin_d[ch]     <= 1'b0;
          capture_value[ch] <= 16'h0000;
          capture_flag[ch]  <= 1'b0;
          cap_blocked[ch]   <= 1'b0;
          cap_armed[ch]     <= 1'b0;
          compare_value[ch] <= `TCC_CMP_RESET;
          cmp_lo_buf[ch]    <= 8'h00;
          compare_flag[ch]  <= 1'b0;
          cmp_blocked[ch]   <= 1'b0;
          cmp_armed[ch]     <= 1'b0;
          o_compare_output_pin[ch] <= 1'b0;
          o_compare_pin_oe[ch]     <= 1'b0;
        end else begin
          cap_pin_d[ch] <= i_capture_input_pin[ch];
          o_compare_pin_oe[ch] <= pin_enable[ch];
          // Capture side; register writes never reach capture_value.
          if (cap_evt) begin
            capture_value[ch] <= counter;
          end
          if (i_rd & (i_addr == a_cap_hi)) begin
            cap_blocked[ch] <= 1'b1;
          end else if (i_rd & (i_addr == a_cap_lo)) begin
            cap_blocked[ch] <= 1'b0;
          end
          if (st_rd & capture_flag[ch]) begin
            cap_armed[ch] <= 1'b1;
          end else if (cap_lo_acc) begin
            cap_armed[ch] <= 1'b0;
          end
          // A capture in the clearing cycle keeps the flag set.
          if (cap_evt) begin
            capture_flag[ch] <= 1'b1;
          end else if (cap_lo_acc & cap_armed[ch]) begin
            capture_flag[ch] <= 1'b0;
          end
          // Compare side: high byte is held until the low byte commits both.
          if (i_wr & (i_addr == a_cmp_hi)) begin
            cmp_lo_buf[ch]  <= i_wdata;
            cmp_blocked[ch] <= 1'b1;
          end else if (i_wr & (i_addr == a_cmp_lo)) begin
            compare_value[ch] <= {(cmp_blocked[ch] ? cmp_lo_buf[ch] :
                                   compare_value[ch][15:8]), i_wdata};
            cmp_blocked[ch]   <= 1'b0;
          end
          if (st_rd & compare_flag[ch]) begin
            cmp_armed[ch] <= 1'b1;
          end else if (cmp_lo_acc) begin
            cmp_armed[ch] <= 1'b0;
          end
          // The low-byte write clears the flag outright; other accesses need
          // the status read first. A match in the same cycle still wins.
          if (cmp_evt & cmp_flag_ok) begin
            compare_flag[ch] <= 1'b1;
          end else if ((cmp_lo_acc & cmp_armed[ch]) |
                       (i_wr & (i_addr == a_cmp_lo))) begin
            compare_flag[ch] <= 1'b0;
          end
          if (cmp_evt & pin_enable[ch]) begin
            o_compare_output_pin[ch] <= out_level[ch];
          end else if (force_bits[ch] & pin_enable[ch] & ~special_mode) begin
            o_compare_output_pin[ch] <= out_level[ch];
          end
        end
      end
    end
  endgenerate

  // Force bits self-clear after one cycle so they act as strobes.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      timer_ctrl_one <= `TCC_CTRL_RESET;
      timer_ctrl_two <= `TCC_CTRL_RESET;
    end else begin
      if (i_wr & (i_addr == `TCC_A_CTRL_ONE)) begin
        timer_ctrl_one <= i_wdata;
      end else begin
        timer_ctrl_one[`TCC_C1_FORCE1] <= 1'b0;
        timer_ctrl_one[`TCC_C1_FORCE2] <= 1'b0;
      end
      if (i_wr & (i_addr == `TCC_A_CTRL_TWO)) begin
        timer_ctrl_two <= i_wdata;
      end
    end
  end

  reg [7:0] next_rdata;
  always @* begin
    case (i_addr)
      `TCC_A_CTRL_ONE: next_rdata = timer_ctrl_one;
      `TCC_A_CTRL_TWO: next_rdata = timer_ctrl_two;
      `TCC_A_STATUS:   next_rdata = {capture_flag[0], compare_flag[0], 1'b0,
                                     capture_flag[1], compare_flag[1], 3'h0};
      `TCC_A_CAP1_HI:  next_rdata = capture_value[0][15:8];
      `TCC_A_CAP1_LO:  next_rdata = capture_value[0][7:0];
      `TCC_A_CMP1_HI:  next_rdata = compare_value[0][15:8];
      `TCC_A_CMP1_LO:  next_rdata = compare_value[0][7:0];
      `TCC_A_CAP2_HI:  next_rdata = capture_value[1][15:8];
      `TCC_A_CAP2_LO:  next_rdata = capture_value[1][7:0];
      `TCC_A_CMP2_HI:  next_rdata = compare_value[1][15:8];
      `TCC_A_CMP2_LO:  next_rdata = compare_value[1][7:0];
      `TCC_A_CNT_HI:   next_rdata = counter[15:8];
      `TCC_A_CNT_LO:   next_rdata = counter[7:0];
      default:         next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata     <= 8'h00;
      o_timer_irq <= 1'b0;
    end else begin
      o_rdata     <= i_rd ? next_rdata : 8'h00;
      // Flags stay set while masked, so the request stays pending.
      o_timer_irq <= ~i_cpu_irq_mask &
                     ((timer_ctrl_one[`TCC_C1_CAP_IE] & (|capture_flag)) |
                      (timer_ctrl_one[`TCC_C1_CMP_IE] & (|compare_flag)));
    end
  end

endmodule
`default_nettype wire

// file: core/timer_cc_regs.vh
// Constants for the timer capture/compare unit: register indices, field positions,
// reset values and clock-select encodings.
// Assumes byte-wide register access over a plain address/strobe port.
//
// Overview of operation
// - Clock select field 11 takes counting from the external count pin.
// - External edge select picks rising or falling external edge to count.
// - Counter updates are aligned to one CPU clock phase.
// - Internal clocking advances counter at CPU clock divided by 2, 4 or 8.
// - Selected capture pin transition latches the 16-bit counter into that channel.
// - Capture registers are read-only; writes leave them unchanged.
// - Capture edge: channel one in control one, channel two in control two.
// - Capture sets flag; interrupt when enabled and CPU mask clear.
// - Capture flag clears after status read then capture low byte access.
// - Reading capture high byte blocks captures and flag until low read.
// - Capture inputs always connected; any qualifying transition captures.
// - In one-pulse or PWM only capture channel two captures.
// - Each timer tick compares counter; match sets flag outside one-pulse or PWM and may interrupt.
// - Compare registers are software read/write, reset to 8000h.
// - Match with output enabled drives pin to level bit; pin low in reset.
// - Compare flag clears after status read then compare low byte access.
// - Compare high write suspends compares; low write resumes and clears flag.
// - Output disabled: pin untouched on match, interrupt still possible.
// - Divide by 2 matches counter equal; others match value plus one.
// - Force bit copies level to enabled pin, no flag, no interrupt.
// - Force bits are ignored in one-pulse or PWM operation.
`ifndef TIMER_CC_REGS_VH
`define TIMER_CC_REGS_VH

`define TCC_ADDR_W        4
`define TCC_A_CTRL_ONE    4'h0
`define TCC_A_CTRL_TWO    4'h1
`define TCC_A_STATUS      4'h2
`define TCC_A_CAP1_HI     4'h3
`define TCC_A_CAP1_LO     4'h4
`define TCC_A_CMP1_HI     4'h5
`define TCC_A_CMP1_LO     4'h6
`define TCC_A_CAP2_HI     4'h7
`define TCC_A_CAP2_LO     4'h8
`define TCC_A_CMP2_HI     4'h9
`define TCC_A_CMP2_LO     4'ha
`define TCC_A_CNT_HI      4'hb
`define TCC_A_CNT_LO      4'hc

// Control one fields.
`define TCC_C1_CAP_IE     7
`define TCC_C1_CMP_IE     6
`define TCC_C1_EDGE1      1
`define TCC_C1_LVL1       0
`define TCC_C1_LVL2       2
`define TCC_C1_FORCE2     3
`define TCC_C1_FORCE1     4
// Control two fields.
`define TCC_C2_PIN1_EN    7
`define TCC_C2_PIN2_EN    6
`define TCC_C2_ONE_PULSE  5
`define TCC_C2_PWM        4
`define TCC_C2_CLK_HI     3
`define TCC_C2_CLK_LO     2
`define TCC_C2_EDGE2      1
`define TCC_C2_EXT_EDGE   0
// Status fields.
`define TCC_ST_CAP1       7
`define TCC_ST_CMP1       6
`define TCC_ST_CAP2       4
`define TCC_ST_CMP2       3

`define TCC_CLK_DIV2      2'h0
`define TCC_CLK_DIV4      2'h1
`define TCC_CLK_DIV8      2'h2
`define TCC_CLK_EXT       2'h3

`define TCC_CMP_RESET     16'h8000
`define TCC_CNT_RESET     16'hfffc
`define TCC_CTRL_RESET    8'h00

`endif

// file: tb/cc_far_side.sv
// Far-side model: capture pulse sources and the external count source.
// Assumes one-cycle requests from the bench on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cc_far_side (
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic [1:0] i_pulse_req,
  input  wire logic       i_ext_run,
  output logic            o_ext_count_pin,
  output logic [1:0]      o_capture_input_pin
);
  logic [3:0] s0;
  logic [3:0] s1;
  logic [2:0] div;
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      s0 <= 4'h0;
      s1 <= 4'h0;
      div <= 3'h0;
    end else begin
      s0 <= {s0[2:0], i_pulse_req[0]};
      s1 <= {s1[2:0], i_pulse_req[1]};
      if (i_ext_run) div <= div + 3'h1;
    end
  end
  // Pulses last four cycles so the two edges of one pulse fall on different counts at divide-by-2 and divide-by-4.
  assign o_capture_input_pin = {|s1, |s0};
  // Eight cycles a period leaves more than four CPU edges between active edges.
  assign o_ext_count_pin = div[2];
endmodule
`default_nettype wire

// file: tb/timer_capture_compare_unit_tb.sv
// Self-checking bench for the timer capture/compare unit.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_regs.vh"
module timer_capture_compare_unit_tb;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, mask = 1, run = 0, irq, ext;
  logic [3:0]  addr = 0;
  logic [7:0]  wd = 0, rdat, x;
  logic [1:0]  req = 0, pin, oe, cap;
  logic [15:0] a, b;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  cc_far_side cc_far_side_i (.i_ref_clk(clk), .i_srst(rst), .i_pulse_req(req),
    .i_ext_run(run), .o_ext_count_pin(ext), .o_capture_input_pin(cap));
  timer_capture_compare_unit timer_capture_compare_unit_i (.i_ref_clk(clk),
    .i_srst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .i_cpu_irq_mask(mask), .i_ext_count_pin(ext), .i_capture_input_pin(cap),
    .o_rdata(rdat), .o_compare_output_pin(pin), .o_compare_pin_oe(oe), .o_timer_irq(irq));
  initial forever #5 clk = ~clk;
  task results;
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr8(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd8(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    d = rdat;
  endtask
  task rchk(input logic [3:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd8(ad, d);
    chk($sformatf("reg %h", ad), e, d);
  endtask
  task rd16(input logic [3:0] hi, output logic [15:0] v);
    rd8(hi, v[15:8]);
    rd8(hi + 4'h1, v[7:0]);
  endtask
  task pulse(input logic [1:0] m);
    @(posedge clk);
    req <= m;
    @(posedge clk);
    req <= 0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    idle(8);
    rst <= 0;
    rchk(`TCC_A_CMP1_HI, 8'h80);
    rchk(`TCC_A_CMP1_LO, 8'h00);
    rchk(`TCC_A_CMP2_HI, 8'h80);
    wr8(4'hd, 8'hff);
    rchk(4'hd, 8'h00);
    wr8(`TCC_A_CMP2_HI, 8'h12);
    wr8(`TCC_A_CMP2_LO, 8'h34);
    rd16(`TCC_A_CMP2_HI, a);
    chk("compare two", 16'h1234, a);
    wr8(`TCC_A_CTRL_ONE, 8'h82);
    for (int s = 0; s < 5; s++) begin
      wr8(`TCC_A_CTRL_TWO, {4'h0, 2'((s > 3) ? 3 : s), 1'b1, s < 4});
      run <= (s >= 3);
      idle(20);
      pulse(2'b01);
      idle(38);
      pulse(2'b10);
      idle(20);
      rd16(`TCC_A_CAP1_HI, a);
      rd16(`TCC_A_CAP2_HI, b);
      chk("capture span", (s == 0) ? 16'd20 : (s == 1) ? 16'd10 : 16'd5, b - a);
    end
    chk("irq masked", 0, irq);
    rchk(`TCC_A_STATUS, 8'h90);
    idle(1);
    mask <= 0;
    idle(3);
    chk("irq pending", 1, irq);
    rchk(`TCC_A_CAP1_LO, a[7:0]);
    rchk(`TCC_A_CAP2_LO, b[7:0]);
    rchk(`TCC_A_STATUS, 8'h00);
    wr8(`TCC_A_CAP1_HI, 8'h55);
    wr8(`TCC_A_CAP1_LO, 8'haa);
    rchk(`TCC_A_CAP1_HI, a[15:8]);
    pulse(2'b01);
    idle(5);
    rchk(`TCC_A_STATUS, 8'h00);
    rchk(`TCC_A_CAP1_LO, a[7:0]);
    wr8(`TCC_A_CTRL_TWO, 8'h00);
    pulse(2'b11);
    idle(10);
    rd16(`TCC_A_CAP1_HI, a);
    rd16(`TCC_A_CAP2_HI, b);
    chk("falling edge two", 16'd2, b - a);
    rchk(`TCC_A_STATUS, 8'h90);
    rd8(`TCC_A_CAP1_LO, x);
    rd8(`TCC_A_CAP2_LO, x);
    wr8(`TCC_A_CTRL_TWO, 8'h22);
    pulse(2'b01);
    idle(8);
    rchk(`TCC_A_STATUS, 8'h00);
    pulse(2'b10);
    idle(8);
    rchk(`TCC_A_STATUS, 8'h10);
    rd8(`TCC_A_CAP2_LO, x);
    wr8(`TCC_A_CTRL_ONE, 8'h45);
    wr8(`TCC_A_CTRL_TWO, 8'h80);
    rd8(`TCC_A_CNT_HI, x);
    for (int c = 5; c < 11; c += 4) begin
      wr8(4'(c), x + 8'h02);
      wr8(4'(c + 1), 8'h00);
    end
    idle(1100);
    chk("pins", 2'b01, pin);
    chk("enables", 2'b01, oe);
    chk("irq compare", 1, irq);
    rchk(`TCC_A_STATUS, 8'h48);
    wr8(`TCC_A_CMP2_HI, 8'h00);
    wr8(`TCC_A_CMP2_LO, 8'h00);
    rchk(`TCC_A_STATUS, 8'h40);
    rd8(`TCC_A_CMP1_LO, x);
    rchk(`TCC_A_STATUS, 8'h00);
    wr8(`TCC_A_CTRL_ONE, 8'h50);
    idle(3);
    chk("forced pin low", 0, pin[0]);
    wr8(`TCC_A_CTRL_ONE, 8'h51);
    idle(3);
    chk("forced pin", 1, pin[0]);
    chk("irq forced", 0, irq);
    rchk(`TCC_A_STATUS, 8'h00);
    wr8(`TCC_A_CTRL_TWO, 8'h88);
    rd16(`TCC_A_CNT_HI, a);
    rd16(`TCC_A_CNT_HI, b);
    // A low byte that went back means the second read straddled a carry.
    if (b[15:8] == a[15:8] && b[7:0] < a[7:0]) b = a;
    b = b + 16'h0004;
    wr8(`TCC_A_CMP1_HI, b[15:8]);
    wr8(`TCC_A_CMP1_LO, b[7:0]);
    x = 8'h00;
    for (int p = 0; p < 40 && !x[6]; p++) rd8(`TCC_A_STATUS, x);
    chk("status at match", 8'h40, x);
    rd8(`TCC_A_CNT_LO, x);
    chk("count at match", 8'(b[7:0] + 8'h01), x);
    wr8(`TCC_A_CTRL_TWO, 8'h90);
    wr8(`TCC_A_CTRL_ONE, 8'h10);
    idle(3);
    chk("force in pwm", 1, pin[0]);
    results;
  end
endmodule
`default_nettype wire

// file: tb/timer_cc_checker_sva.sv
// Port-level assertions for the timer capture/compare unit.
// Assumes it is bound to the unit; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_regs.vh"
module timer_cc_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_cpu_irq_mask,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_compare_output_pin,
  input wire logic [1:0] o_compare_pin_oe,
  input wire logic       o_timer_irq
);
  logic [7:0] c2;
  logic [1:0] ie;
  logic       susp;
  // Shadow copies of control and compare-one writes, so no assertion needs to look inside the unit.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      c2 <= 8'h00;
      ie <= 2'h0;
      susp <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `TCC_A_CTRL_TWO) c2 <= i_wdata;
      if (i_addr == `TCC_A_CTRL_ONE) ie <= i_wdata[7:6];
      if (i_addr == `TCC_A_CMP1_HI) susp <= 1'b1;
      if (i_addr == `TCC_A_CMP1_LO) susp <= 1'b0;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_force1;
    i_wr && i_addr == `TCC_A_CTRL_ONE && i_wdata[4] && i_wdata[0]
      && o_compare_pin_oe[0] && c2[5:4] == 2'h0;
  endsequence
  sequence s_pin1_high;
    ##[1:3] o_compare_output_pin[0];
  endsequence
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  property p_unmapped;
    $past(i_rd) && $past(i_addr) > `TCC_A_CNT_LO |-> o_rdata == 8'h00;
  endproperty
  property p_rst_pin;
    $past(i_srst) |-> o_compare_output_pin == 2'h0 && !o_timer_irq;
  endproperty
  property p_oe; $stable(c2[7:6]) |-> o_compare_pin_oe == {c2[6], c2[7]}; endproperty
  property p_dis_stable;
    !o_compare_pin_oe[1] && $past(!o_compare_pin_oe[1]) |-> $stable(o_compare_output_pin[1]);
  endproperty
  property p_irq;
    $rose(o_timer_irq) |-> !$past(i_cpu_irq_mask) && $past(ie) != 2'h0;
  endproperty
  property p_force; s_force1 |-> s_pin1_high; endproperty
  property p_susp; susp && $past(susp) |-> $stable(o_compare_output_pin[0]); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rst_pin: assert property (p_rst_pin) else $error("pins not low after reset");
  a_oe: assert property (p_oe) else $error("pin enable mismatch");
  a_dis_stable: assert property (p_dis_stable) else $error("disabled pin moved");
  a_irq: assert property (p_irq) else $error("interrupt not qualified");
  a_force: assert property (p_force) else $error("forced level missing");
  a_susp: assert property (p_susp) else $error("suspended compare acted");
endmodule
bind timer_capture_compare_unit timer_cc_checker timer_cc_checker_i (.i_ref_clk, .i_srst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .i_cpu_irq_mask, .o_rdata, .o_compare_output_pin,
  .o_compare_pin_oe, .o_timer_irq);
`default_nettype wire
